// File: src/ccs_supervisor.sv
`timescale 1ns/1ps
module ccs_supervisor
    import ccs_pkg::*;
#(
    parameter int TICK_CYCLES  = TICK_CYC,
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Host control bits and strobes
    input  wire ccs_ctrl_t  host_ctrl,
    input  wire logic       host_wr,
    input  wire logic       host_kick,
    input  wire logic       host_param_reset,
    input  wire logic       status_rd,
    output logic            kick_done,
    output logic            param_reset_done,
    // Analog comparators and supply events
    input  wire ccs_sense_t sense,
    input  wire logic       vbus_por,
    input  wire logic       port_select_pin,
    // Power stage
    output ccs_param_t      applied,
    output logic            pwm_en,
    output logic            rev_sw_en,
    output logic            lowside_sync,
    output logic            short_mode,
    // Status
    output ccs_cond_t       charger_condition_field,
    output ccs_fault_t      fault_code,
    output logic            timer_short_mode,
    output logic            stat_o,
    output logic            stat_oe
);
    localparam int TB_W = $clog2(TICK_CYCLES + 1);
    localparam int PW   = $clog2(PULSE_CYCLES + 1);

    // ========================================
    // Helpers
    function automatic ccs_state_t entry_phase(input ccs_sense_t s);
        entry_phase = s.vbat_below_short ? ST_SHORT : ST_FAST;
    endfunction : entry_phase

    function automatic logic [VREG_W-1:0] vreg_clamp(
        input logic [VREG_W-1:0] c);
        vreg_clamp = (c > VREG_MAX_CODE) ? VREG_MAX_CODE : c;
    endfunction : vreg_clamp

    ccs_state_t        state_r;
    ccs_state_t        state_nxt;
    logic [TB_W-1:0]   tb_cnt_r;
    logic [TMR_W-1:0]  tmr_cnt_r;
    logic [TMR_W-1:0]  retry_cnt_r;
    logic [PW-1:0]     pulse_cnt_r;
    logic              tmode_short_r;
    logic              therm_r;
    logic              dflt_r;
    logic              fallback_r;
    logic              tmr_fault_r;
    logic              held_r;
    logic              ce_prev_r;
    logic [3:0]        lvl_prev_r;
    logic              stat_oe_r;

    logic              suspend;
    logic              charging;
    logic              tick;
    logic              short_exp;
    logic              long_exp;
    logic              retry_done;
    logic              start;
    logic              por_start;
    logic [3:0]        lvl;
    logic              fault_ev;
    ccs_fault_t        ev_code;

    // Thermal and overvoltage win
    assign suspend  = therm_r | sense.die_trip |
                      sense.in_ovp;
    assign charging = (state_r == ST_SHORT) | (state_r == ST_FAST) |
                      (state_r == ST_CV);

    // ========================================
    // Timebase, frozen while too hot
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tb_cnt_r <= '0;
        end else if (!therm_r) begin
            tb_cnt_r <= tick ? '0 : tb_cnt_r + 1'b1;
        end
    end
    assign tick = !therm_r && (tb_cnt_r == TB_W'(TICK_CYCLES - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            therm_r <= 1'b0;
        end else if (sense.die_trip) begin
            therm_r <= 1'b1;
        end else if (sense.die_cooled) begin
            therm_r <= 1'b0;
        end
    end

    // ========================================
    // Restart sources
    assign por_start  = vbus_por & sense.vbat_below_weak;
    assign retry_done = (state_r == ST_RETRY) & tick &
                        (retry_cnt_r == TMR_W'(RETRY_TICKS - 1));
    assign start = por_start | host_param_reset | short_exp | retry_done |
                   (ce_prev_r & !host_ctrl.charge_disable) |
                   ((state_r == ST_DONE) & !sense.vbat_above_rch);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ce_prev_r <= 1'b0;
        end else begin
            ce_prev_r <= host_ctrl.charge_disable;
        end
    end

    // ========================================
    // Safety timers: long until the host writes, then short
    assign short_exp = tmode_short_r & tick & charging & !suspend &
                       (tmr_cnt_r == TMR_W'(SHORT_TICKS - 1));
    assign long_exp  = !tmode_short_r & tick & charging & !suspend &
                       (tmr_cnt_r == TMR_W'(LONG_TICKS - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmode_short_r <= 1'b0;
            tmr_cnt_r     <= '0;
        end else if (start) begin
            tmode_short_r <= 1'b0;
            tmr_cnt_r     <= '0;
        end else if (host_wr && !tmode_short_r) begin
            tmode_short_r <= 1'b1;
            tmr_cnt_r     <= '0;
        end else if (host_kick && tmode_short_r) begin
            tmr_cnt_r <= '0;
        end else if (tick && charging && !suspend) begin
            tmr_cnt_r <= tmr_cnt_r + 1'b1;
        end
    end
    assign timer_short_mode = tmode_short_r;
    // Host-side bits clear on these strobes
    assign kick_done        = host_kick;
    assign param_reset_done = host_param_reset;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmr_fault_r <= 1'b0;
        end else if (vbus_por) begin
            tmr_fault_r <= 1'b0;
        end else if (long_exp) begin
            tmr_fault_r <= 1'b1;
        end
    end

    // ========================================
    // Default parameters and boot fallback
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dflt_r     <= 1'b1;
            fallback_r <= 1'b0;
        end else if (vbus_por && sense.vbat_below_weak && !tmode_short_r) begin
            dflt_r     <= 1'b1;
            fallback_r <= 1'b1;
        end else if (short_exp || host_param_reset) begin
            dflt_r <= 1'b1;
        end else if (host_wr) begin
            // A host write takes over from the defaults unless a fallback POR, short expiry or reset bit wins
            dflt_r     <= 1'b0;
            fallback_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            applied.input_current_limit <= ILIM_100;
            applied.regulation_voltage  <= VREG_DEF_CODE;
            applied.fast_current        <= ICHG_DEF;
            applied.termination_current <= TERMINATION_CURRENT_DEF;
            applied.term_en             <= TERM_EN_DEF;
        end else if (dflt_r) begin
            applied.input_current_limit <= (fallback_r && port_select_pin) ?
                                           ILIM_500 : ILIM_100;
            applied.regulation_voltage  <= VREG_DEF_CODE;
            applied.fast_current        <= ICHG_DEF;
            applied.termination_current <= TERMINATION_CURRENT_DEF;
            applied.term_en             <= TERM_EN_DEF;
        end else begin
            applied.input_current_limit <=
                host_ctrl.input_current_limit;
            applied.regulation_voltage  <=
                vreg_clamp(host_ctrl.regulation_voltage);
            applied.fast_current        <= host_ctrl.fast_current;
            applied.termination_current <= host_ctrl.termination_current;
            applied.term_en             <= host_ctrl.term_en;
        end
    end

    // ========================================
    // Charge phase sequencer
    always_comb begin
        state_nxt = state_r;
        if (tmr_fault_r) begin
            state_nxt = vbus_por ? entry_phase(sense) : ST_TMR_FAULT;
        end else if (long_exp) begin
            state_nxt = ST_TMR_FAULT;
        end else if (suspend) begin
            state_nxt = state_r;
        end else if (host_ctrl.charge_disable) begin
            state_nxt = ST_OFF;
        end else if (charging && sense.poor_src) begin
            state_nxt = ST_RETRY;
        end else if (start) begin
            state_nxt = entry_phase(sense);
        end else begin
            unique case (state_r)
                ST_SHORT: begin
                    if (!sense.vbat_below_short) state_nxt = ST_FAST;
                end
                ST_FAST: begin
                    if (sense.vbat_below_short) state_nxt = ST_SHORT;
                    else if (sense.vbat_at_reg) state_nxt = ST_CV;
                end
                ST_CV: begin
                    if (applied.term_en && sense.ichg_at_term &&
                        sense.vbat_above_rch) begin
                        state_nxt = ST_DONE;
                    end else if (!sense.vbat_at_reg) begin
                        state_nxt = ST_FAST;
                    end
                end
                ST_OFF, ST_DONE, ST_RETRY, ST_TMR_FAULT: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_SHORT;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            retry_cnt_r <= '0;
        end else if (state_r != ST_RETRY) begin
            retry_cnt_r <= '0;
        end else if (tick) begin
            retry_cnt_r <= retry_cnt_r + 1'b1;
        end
    end

    // ========================================
    // Power stage drive
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pwm_en       <= 1'b0;
            short_mode   <= 1'b0;
            rev_sw_en    <= 1'b0;
            lowside_sync <= 1'b0;
        end else begin
            pwm_en       <= ((state_nxt == ST_FAST) || (state_nxt == ST_CV)) &&
                            !suspend && !sense.sleep;
            short_mode   <= (state_nxt == ST_SHORT) && !suspend &&
                            !sense.sleep;
            rev_sw_en    <= !sense.sleep;
            // Cut the low side early so current never flows back
            lowside_sync <= ((state_nxt == ST_FAST) || (state_nxt == ST_CV)) &&
                            !suspend && !sense.sleep &&
                            sense.ls_above_100ma;
        end
    end

    // ========================================
    // Fault status, held until the host reads it
    assign lvl = {therm_r, sense.in_ovp, charging & sense.poor_src,
                  sense.sleep};

    always_comb begin
        ev_code = FLT_NONE;
        if (lvl[3] && !lvl_prev_r[3]) ev_code = FLT_THERMAL;
        else if (lvl[2] && !lvl_prev_r[2]) ev_code = FLT_IN_OVP;
        else if (long_exp) ev_code = FLT_TIMER;
        else if (lvl[1] && !lvl_prev_r[1]) ev_code = FLT_POOR_SRC;
        else if (lvl[0] && !lvl_prev_r[0]) ev_code = FLT_SLEEP;
    end
    assign fault_ev = (ev_code != FLT_NONE);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lvl_prev_r <= '0;
        end else begin
            lvl_prev_r <= lvl;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_code <= FLT_NONE;
            held_r     <= 1'b0;
        end else if (fault_ev && (!held_r || status_rd)) begin
            fault_code <= ev_code;
            held_r     <= 1'b1;
        end else if (status_rd) begin
            fault_code <= tmr_fault_r ? FLT_TIMER : FLT_NONE;
            held_r     <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            charger_condition_field <= COND_READY;
        end else if (tmr_fault_r || (fault_code != FLT_NONE)) begin
            charger_condition_field <= COND_FAULT;
        end else if (charging) begin
            charger_condition_field <= COND_CHARGING;
        end else if (state_r == ST_DONE) begin
            charger_condition_field <= COND_DONE;
        end else begin
            charger_condition_field <= COND_READY;
        end
    end

    // ========================================
    // Indicator pin: low while charging, one pulse per fault
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_r <= '0;
        end else if (fault_ev) begin
            pulse_cnt_r <= PW'(PULSE_CYCLES);
        end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stat_oe_r <= 1'b0;
        end else begin
            stat_oe_r <= fault_ev || (pulse_cnt_r > PW'(1)) ||
                         (charging && host_ctrl.en_stat);
        end
    end
    assign stat_oe = stat_oe_r;
    assign stat_o  = 1'b0;
endmodule : ccs_supervisor

// File: inc/ccs_pkg.sv
// What this block does
// - Below short-circuit threshold: short-circuit mode, reduced current.
// - Above short threshold: fast current, input limit default 100 mA.
// - Regulation voltage code spans 3.5 V to 4.44 V, set by the host.
// - In regulation, end at termination current above recharge threshold.
// - Termination enable at 0 means charge never ends on low current.
// - Restart: recharge drop, weak-cell POR, disable toggle or reset bit.
// - Start long safety timer at charge start; any host write stops it.
// - Stopping the long timer starts the short safety timer.
// - Host kick restarts the short timer; the kick bit self-clears.
// - Short timer expiry: stop, restore defaults, restart long timer, resume.
// - Long timer expiry: charger off, fault shown in charger condition field.
// - Timer fault cleared only by supply reset; status held until read.
// - Supply reset with good cell or short-timer mode keeps host settings.
// - Weak-cell supply reset in long-timer mode: defaults, charge enabled.
// - Fallback input limit: 100 mA with port select low, 500 mA high.
// - After reset termination off and regulation voltage 3.54 V.
// - Input limit is 100 mA or 500 mA, or disabled by the host.
// - Thermal trip: charge suspended, PWM off, timers frozen until cooled.
// - Sleep turns off reverse-blocking switch and PWM converter.
// - Poor source ends charge, waits retry delay, then charges again.
// - Input overvoltage: PWM off, fault status, pulse; resume on exit.
// - Low-side switch runs synchronously only above 100 mA.
// - Each fault gives one 128 us active indicator pulse, then open drain.
// - Charge-disable bit 0 allows charging, 1 inhibits it.
// - Parameter reset bit restores defaults and self-clears.
package ccs_pkg;
    // ========================================
    // Timing
    localparam int CLK_MHZ        = 50;
    localparam int TICK_S         = 1;
    localparam int TICK_CYC       = TICK_S * CLK_MHZ * 1000000;
    localparam int LONG_TIMER_MIN = 32;
    localparam int LONG_TICKS     = LONG_TIMER_MIN * 60 / TICK_S;
    localparam int SHORT_TIMER_S  = 32;
    localparam int SHORT_TICKS    = SHORT_TIMER_S / TICK_S;
    localparam int RETRY_DELAY_S  = 2;
    localparam int RETRY_TICKS    = RETRY_DELAY_S / TICK_S;
    localparam int PULSE_US       = 128;
    localparam int PULSE_CYC      = PULSE_US * CLK_MHZ;
    localparam int TMR_W          = 11;

    // ========================================
    // Charge parameters
    localparam int VREG_W       = 6;
    localparam int VREG_BASE_MV = 3500;
    localparam int VREG_STEP_MV = 20;
    localparam int VREG_MAX_MV  = 4440;
    localparam int VREG_DEF_MV  = 3540;
    localparam logic [VREG_W-1:0] VREG_MAX_CODE =
        VREG_W'((VREG_MAX_MV - VREG_BASE_MV) / VREG_STEP_MV);
    localparam logic [VREG_W-1:0] VREG_DEF_CODE =
        VREG_W'((VREG_DEF_MV - VREG_BASE_MV) / VREG_STEP_MV);
    localparam logic [2:0] ICHG_DEF    = 3'h0;
    localparam logic [2:0] TERMINATION_CURRENT_DEF   = 3'h1;
    localparam logic       TERM_EN_DEF = 1'b0;

    typedef enum logic [1:0] {ILIM_100, ILIM_500, ILIM_NONE} ccs_ilim_t;
    typedef enum logic [1:0] {
        COND_READY, COND_CHARGING, COND_DONE, COND_FAULT
    } ccs_cond_t;
    typedef enum logic [2:0] {
        FLT_NONE, FLT_THERMAL, FLT_SLEEP, FLT_POOR_SRC, FLT_IN_OVP, FLT_TIMER
    } ccs_fault_t;
    typedef enum logic [2:0] {
        ST_OFF, ST_SHORT, ST_FAST, ST_CV, ST_DONE, ST_RETRY, ST_TMR_FAULT
    } ccs_state_t;

    // Host-side control bits
    typedef struct packed {
        logic              charge_disable;
        logic              term_en;
        ccs_ilim_t         input_current_limit;
        logic [VREG_W-1:0] regulation_voltage;
        logic [2:0]        fast_current;
        logic [2:0]        termination_current;
        logic              en_stat;
    } ccs_ctrl_t;

    // Parameters handed to the analog loops
    typedef struct packed {
        ccs_ilim_t         input_current_limit;
        logic [VREG_W-1:0] regulation_voltage;
        logic [2:0]        fast_current;
        logic [2:0]        termination_current;
        logic              term_en;
    } ccs_param_t;

    // Comparator outputs, synchronous to mclk
    typedef struct packed {
        logic vbat_below_short;
        logic vbat_below_weak;
        logic vbat_above_rch;
        logic vbat_at_reg;
        logic ichg_at_term;
        logic die_trip;
        logic die_cooled;
        logic sleep;
        logic poor_src;
        logic in_ovp;
        logic ls_above_100ma;
    } ccs_sense_t;
endpackage : ccs_pkg

// File: tb/ccs_supervisor_asserts.sv
`timescale 1ns/1ps
module ccs_supervisor_asserts
    import ccs_pkg::*;
#(
    parameter int TICK_CYCLES  = 10,
    parameter int PULSE_CYCLES = 8
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       resetn,
    // Host side and sense
    input wire ccs_ctrl_t  host_ctrl,
    input wire logic       host_wr,
    input wire logic       host_kick,
    input wire logic       host_param_reset,
    input wire logic       kick_done,
    input wire logic       param_reset_done,
    input wire logic       status_rd,
    input wire ccs_sense_t sense,
    input wire logic       vbus_por,
    // Block outputs
    input wire logic       pwm_en,
    input wire logic       rev_sw_en,
    input wire logic       lowside_sync,
    input wire logic       short_mode,
    input wire ccs_fault_t fault_code,
    input wire logic       timer_short_mode,
    input wire logic       stat_o,
    input wire logic       stat_oe
);
    // ========================================
    // Pulse length
    int unsigned run_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_r <= 0;
        end else if (stat_oe) begin
            run_r <= run_r + 1;
        end else begin
            run_r <= 0;
        end
    end

    // ========================================
    // Properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_long_wr;
        host_wr && !timer_short_mode && pwm_en && !vbus_por
            && !host_param_reset;
    endsequence
    // Held enable stretches the pulse
    sequence s_pulse_end;
        $fell(stat_oe) && !host_ctrl.en_stat;
    endsequence

    property p_wr;    s_long_wr |=> timer_short_mode; endproperty
    property p_pulse; s_pulse_end |-> run_r == PULSE_CYCLES; endproperty
    property p_kick;  kick_done == host_kick; endproperty
    property p_prst;  param_reset_done == host_param_reset; endproperty
    property p_ovp;   sense.in_ovp |=> !pwm_en; endproperty
    property p_trip;  sense.die_trip |=> !pwm_en; endproperty
    property p_sleep; sense.sleep |=> !rev_sw_en && !pwm_en; endproperty
    property p_lows;  !sense.ls_above_100ma |=> !lowside_sync; endproperty
    property p_short; short_mode |-> !pwm_en; endproperty
    property p_hold;
        fault_code != FLT_NONE && !status_rd |=> $stable(fault_code);
    endproperty
    property p_stat;  stat_oe |-> !stat_o; endproperty

    a_wr: assert property (p_wr)
        else $error("Write kept long timer");
    a_pulse: assert property (p_pulse)
        else $error("Bad pulse length");
    a_kick: assert property (p_kick)
        else $error("Kick ack mismatch");
    a_prst: assert property (p_prst)
        else $error("Reset ack mismatch");
    a_ovp: assert property (p_ovp)
        else $error("PWM on in overvoltage");
    a_trip: assert property (p_trip)
        else $error("PWM on in thermal trip");
    a_sleep: assert property (p_sleep)
        else $error("Power on in sleep");
    a_lows: assert property (p_lows)
        else $error("Low side sync at low current");
    a_short: assert property (p_short)
        else $error("PWM on in short mode");
    a_hold: assert property (p_hold)
        else $error("Fault code changed unread");
    a_stat: assert property (p_stat)
        else $error("Pin driven high");
endmodule : ccs_supervisor_asserts

// File: tb/ccs_host_model.sv
`timescale 1ns/1ps
module ccs_host_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Requests from the bench
    input  wire logic req_kick,
    input  wire logic req_reset,
    // Self-clearing control bits
    output logic      host_kick,
    output logic      host_param_reset,
    input  wire logic kick_done,
    input  wire logic param_reset_done
);
    // ========================================
    // Bits stay set until the block acknowledges them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            host_kick <= 1'b0;
        end else if (kick_done) begin
            host_kick <= 1'b0;
        end else if (req_kick) begin
            host_kick <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            host_param_reset <= 1'b0;
        end else if (param_reset_done) begin
            host_param_reset <= 1'b0;
        end else if (req_reset) begin
            host_param_reset <= 1'b1;
        end
    end
endmodule : ccs_host_model

// File: tb/tb_ccs_supervisor.sv
`timescale 1ns/1ps
module tb_ccs_supervisor
    import ccs_pkg::*;
;
    // ========================================
    // Short timebase: long timer near 19200 cycles
    localparam int TICKS = 10;
    localparam int PULSE = 8;
    localparam int RST = 0, KICK = 1, WR = 2, RD = 3, POR = 4;
    localparam ccs_ctrl_t  DCTL =
        '{1'b0, 1'b0, ILIM_100, 6'h02, 3'h0, 3'h1, 1'b0};
    localparam ccs_ctrl_t  PROG =
        '{1'b0, 1'b1, ILIM_NONE, 6'h2f, 3'h5, 3'h3, 1'b0};
    localparam ccs_param_t DFLT = '{ILIM_100, 6'h02, 3'h0, 3'h1, 1'b0};
    localparam ccs_param_t PEXP = '{ILIM_NONE, 6'h2f, 3'h5, 3'h3, 1'b1};
    logic        mclk, resetn, host_wr, host_kick, host_param_reset;
    logic        status_rd, kick_done, param_reset_done, vbus_por;
    logic        port_select_pin, pwm_en, rev_sw_en, lowside_sync;
    logic        short_mode, timer_short_mode, stat_o, stat_oe;
    logic        req_kick, req_reset;
    logic [15:0] n;
    ccs_ctrl_t   host_ctrl;
    ccs_sense_t  sense;
    ccs_param_t  applied;
    ccs_cond_t   charger_condition_field;
    ccs_fault_t  fault_code;
    int          failures, n_checks;

    ccs_supervisor #(.TICK_CYCLES(TICKS), .PULSE_CYCLES(PULSE))
        ccs_supervisor_inst (
        .mclk, .resetn, .host_ctrl, .host_wr, .host_kick, .host_param_reset,
        .status_rd, .kick_done, .param_reset_done, .sense, .vbus_por,
        .port_select_pin, .applied, .pwm_en, .rev_sw_en, .lowside_sync,
        .short_mode, .charger_condition_field, .fault_code,
        .timer_short_mode, .stat_o, .stat_oe
    );
    ccs_host_model ccs_host_model_inst (
        .mclk, .resetn, .req_kick, .req_reset, .host_kick,
        .host_param_reset, .kick_done, .param_reset_done
    );

    always #10 mclk = ~mclk;

    // ========================================
    // Tasks
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc

    task automatic strobe(input int k);
        @(negedge mclk);
        {vbus_por, status_rd, host_wr, req_kick, req_reset} = 5'h1 << k;
        @(negedge mclk);
        {vbus_por, status_rd, host_wr, req_kick, req_reset} = 5'h0;
    endtask : strobe

    task automatic wr(input ccs_ctrl_t v);
        host_ctrl = v;
        strobe(WR);
    endtask : wr

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic pw(input logic e);
        chk("pwm_en", 16'(pwm_en), 16'(e));
    endtask : pw

    task automatic summarize();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // ========================================
    // Tests
    initial begin
        {mclk, resetn, host_wr, status_rd, vbus_por} = 5'h0;
        {port_select_pin, req_kick, req_reset} = 3'h0;
        host_ctrl = DCTL;
        sense = '0;
        sense.vbat_below_short = 1'b1;
        sense.vbat_below_weak = 1'b1;
        cyc(20);
        resetn = 1'b1;
        cyc(2);
        chk("applied", 16'(applied), 16'(DFLT));
        chk("short_mode", 16'(short_mode), 16'h1);
        chk("tmode", 16'(timer_short_mode), 16'h0);
        sense.vbat_below_short = 1'b0;
        cyc(2);
        pw(1'b1);
        chk("short_mode", 16'(short_mode), 16'h0);
        wr(PROG);
        cyc(3);
        chk("tmode", 16'(timer_short_mode), 16'h1);
        chk("applied", 16'(applied), 16'(PEXP));
        repeat (2) begin
            cyc(250);
            strobe(KICK);
        end
        cyc(1);
        chk("tmode", 16'(timer_short_mode), 16'h1);
        chk("kick bit", 16'(host_kick), 16'h0);
        cyc(350);
        chk("tmode", 16'(timer_short_mode), 16'h0);
        chk("applied", 16'(applied), 16'(DFLT));
        pw(1'b1);
        wr(PROG);
        strobe(RST);
        cyc(3);
        chk("applied", 16'(applied), 16'(DFLT));
        chk("reset bit", 16'(host_param_reset), 16'h0);
        {sense.vbat_at_reg, sense.ichg_at_term, sense.vbat_above_rch} = 3'h7;
        cyc(5);
        pw(1'b1);
        wr(PROG);
        cyc(5);
        pw(1'b0);
        chk("cond", 16'(charger_condition_field), 16'(COND_DONE));
        sense.vbat_above_rch = 1'b0;
        cyc(5);
        pw(1'b1);
        {sense.vbat_at_reg, sense.ichg_at_term} = 2'h0;
        wr(PROG | 17'h10000);
        cyc(3);
        pw(1'b0);
        wr(PROG);
        cyc(3);
        pw(1'b1);
        strobe(RD);
        sense.in_ovp = 1'b1;
        n = 16'h0;
        repeat (20) begin
            @(negedge mclk);
            n = n + 16'(stat_oe);
        end
        chk("pulse", n, 16'(PULSE));
        chk("fault", 16'(fault_code), 16'(FLT_IN_OVP));
        sense.in_ovp = 1'b0;
        cyc(3);
        pw(1'b1);
        strobe(RD);
        sense.die_trip = 1'b1;
        cyc(20);
        chk("fault", 16'(fault_code), 16'(FLT_THERMAL));
        {sense.die_trip, sense.die_cooled} = 2'h1;
        cyc(3);
        pw(1'b1);
        sense.die_cooled = 1'b0;
        strobe(RD);
        sense.sleep = 1'b1;
        cyc(20);
        chk("rev_sw_en", 16'(rev_sw_en), 16'h0);
        sense.sleep = 1'b0;
        strobe(RD);
        sense.poor_src = 1'b1;
        cyc(2);
        sense.poor_src = 1'b0;
        cyc(2);
        pw(1'b0);
        cyc(40);
        pw(1'b1);
        strobe(RD);
        cyc(19800);
        pw(1'b0);
        chk("cond", 16'(charger_condition_field), 16'(COND_FAULT));
        chk("fault", 16'(fault_code), 16'(FLT_TIMER));
        strobe(RD);
        wr(PROG);
        cyc(3);
        pw(1'b0);
        strobe(POR);
        cyc(5);
        pw(1'b1);
        chk("applied", 16'(applied), 16'(PEXP));
        for (int p = 0; p < 2; p++) begin
            port_select_pin = p[0];
            strobe(POR);
            cyc(3);
            chk("ilim", 16'(applied.input_current_limit),
                p ? 16'(ILIM_500) : 16'(ILIM_100));
            pw(1'b1);
        end
        summarize();
    end

    initial begin
        repeat (24000) @(posedge mclk);
        failures++;
        summarize();
    end
endmodule : tb_ccs_supervisor

bind ccs_supervisor ccs_supervisor_asserts #(
    .TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) ccs_supervisor_asserts_inst (
    .mclk, .resetn, .host_ctrl, .host_wr, .host_kick, .host_param_reset,
    .kick_done, .param_reset_done, .status_rd, .sense, .vbus_por, .pwm_en,
    .rev_sw_en, .lowside_sync, .short_mode, .fault_code,
    .timer_short_mode, .stat_o, .stat_oe
);
